/* File: rtl/psc_strap_loader.sv */
// Strap-pin configuration loader and switch control registers.
// Assumes a serial engine on clk presents one-cycle register accesses.
// What this block does
// - Output termination bit: 0 disconnects, 1 connects all output terminations.
// - Output current bit: 0 gives 10 mA drive, 1 gives 20 mA.
// - Registers load from the strap pins through a two-flop synchroniser.
// - Straps apply after reset only until the first serial register access.
// - Strap mode forces quad high speed mode, mode bits 5:2 zero.
// - Strapped channel enable drives fast mode bit 6; 0 standby, 1 on.
// - Strapped source select drives fast mode bits 1:0, A to D.
// - Strap mode holds the auxiliary switch enabled and in quad mode.
// - Same source select drives auxiliary mode bits 1:0.
// - Strap mode fixes input termination enable bit 0 to 1.
// - Strap mode clears both termination pulse registers.
// - Strapped equalization level copied to every equalizer bit.
// - Drive register: boost in 3:2, termination bit 1, current bit 0.
// - Boost code 00 none, 01 low, 10 medium, 11 high.
// - Equalization bit 0 low 6 dB, 1 high 12 dB.
// - Pulse bit 1 drops that input termination 100 ms on source change.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_strap_loader
  import psc_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = `PSC_CLK_HZ / 1000 * `PSC_PULSE_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic strapChannelEnable,
  input wire logic [1:0] strapSourceSelect,
  input wire logic strapEqLevel,
  input wire logic [1:0] strapBoostPins,
  input wire logic strapOutTerm,
  input wire logic strapOutCurrent,
  input wire logic serReq,
  input wire logic serWrite,
  input wire logic [`PSC_IDX_W-1:0] serIdx,
  input wire logic [7:0] serWdata,
  output logic [7:0] serRdata,
  output logic serRvalid,
  output logic strapMode,
  output logic hsEnable,
  output logic [3:0] hsMode,
  output logic [1:0] hsSource,
  output logic auxEnable,
  output logic [3:0] auxMode,
  output logic [1:0] auxSource,
  output logic [15:0] inTermOn,
  output logic [15:0] eqHigh,
  output logic [1:0] outBoostLevel,
  output logic outTermEnable,
  output logic outCurrentHigh
);
  localparam int unsigned CW = `PSC_PULSE_CNT_W;
  localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_CYCLES - 1);

  logic [1:0] rstPipe;
  logic rstSync_b;
  psc_core_t q;
  psc_core_t d;
  logic [7:0] fastImg;
  logic [7:0] sideImg;
  logic [7:0] driveImg;
  logic [7:0] eqImg;
  logic [7:0] fastReg;
  logic [7:0] sideReg;
  logic [7:0] driveReg;
  logic [15:0] pulseBits;
  logic [15:0] eqBits;
  logic inTermEn;
  logic srcChanged;

  psc_strap_if strapBus ();

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe[1];

  // Pins are static levels, so two flops are enough
  psc_strap_sync u_sync (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .strapPins({strapOutCurrent, strapOutTerm, strapBoostPins,
                strapEqLevel, strapSourceSelect, strapChannelEnable}),
    .strap(strapBus.syncSide)
  );

  // Strap register images
  always_comb begin
    fastImg = `PSC_FAST_RST;
    fastImg[`PSC_BIT_ENABLE] = strapBus.strapChannelEnable;
    fastImg[`PSC_MODE_HI:`PSC_MODE_LO] = `PSC_MODE_QUAD;
    fastImg[`PSC_SRC_HI:`PSC_SRC_LO] = strapBus.strapSourceSelect;
    sideImg = `PSC_SIDE_RST;
    sideImg[`PSC_MODE_HI:`PSC_MODE_LO] = `PSC_MODE_QUAD;
    sideImg[`PSC_SRC_HI:`PSC_SRC_LO] = strapBus.strapSourceSelect;
    eqImg = {8{strapBus.strapEqLevel}};
    driveImg = `PSC_ZERO_RST;
    driveImg[`PSC_BOOST_HI:`PSC_BOOST_LO] = strapBus.strapBoostLevel;
    driveImg[`PSC_BIT_OUT_TERM] = strapBus.strapOutTerm;
    driveImg[`PSC_BIT_OUT_CUR] = strapBus.strapOutCurrent;
  end

  // Views of the stored registers
  always_comb begin
    fastReg = q.regFile[`PSC_IDX_FAST];
    sideReg = q.regFile[`PSC_IDX_SIDE];
    driveReg = q.regFile[`PSC_IDX_DRIVE];
    pulseBits = {q.regFile[`PSC_IDX_PULSE_CD], q.regFile[`PSC_IDX_PULSE_AB]};
    eqBits = {q.regFile[`PSC_IDX_EQ_CD], q.regFile[`PSC_IDX_EQ_AB]};
    inTermEn = q.regFile[`PSC_IDX_INTERM][`PSC_BIT_IN_TERM];
    srcChanged = fastReg[`PSC_SRC_HI:`PSC_SRC_LO] != q.lastSrc;
  end

  always_comb begin
    d = q;
    d.rdValid = 1'b0;

    // Track straps every cycle until the serial side takes over
    if (q.strapMode) begin
      d.regFile[`PSC_IDX_FAST] = fastImg;
      d.regFile[`PSC_IDX_SIDE] = sideImg;
      d.regFile[`PSC_IDX_INTERM] = `PSC_INTERM_RST;
      d.regFile[`PSC_IDX_PULSE_AB] = `PSC_ZERO_RST;
      d.regFile[`PSC_IDX_PULSE_CD] = `PSC_ZERO_RST;
      d.regFile[`PSC_IDX_EQ_AB] = eqImg;
      d.regFile[`PSC_IDX_EQ_CD] = eqImg;
      d.regFile[`PSC_IDX_DRIVE] = driveImg;
    end

    // First access ends strap mode until the next reset
    if (serReq) begin
      d.strapMode = 1'b0;
      if (serWrite) begin
        d.regFile[serIdx] = serWdata;
      end else begin
        // Reads return the value as it stood before this cycle
        d.rdData = q.regFile[serIdx];
        d.rdValid = 1'b1;
      end
    end

    // Termination pulse timer; a new change restarts it
    d.lastSrc = fastReg[`PSC_SRC_HI:`PSC_SRC_LO];
    if (srcChanged) begin
      d.pulseOn = 1'b1;
      d.pulseCnt = PULSE_LOAD;
    end else if (q.pulseOn) begin
      if (q.pulseCnt == '0) begin
        d.pulseOn = 1'b0;
      end else begin
        d.pulseCnt = q.pulseCnt - CW'(1);
      end
    end

    // Datapath controls
    d.hsEnable = fastReg[`PSC_BIT_ENABLE];
    d.hsMode = fastReg[`PSC_MODE_HI:`PSC_MODE_LO];
    d.hsSource = fastReg[`PSC_SRC_HI:`PSC_SRC_LO];
    d.auxEnable = sideReg[`PSC_BIT_ENABLE];
    d.auxMode = sideReg[`PSC_MODE_HI:`PSC_MODE_LO];
    d.auxSource = sideReg[`PSC_SRC_HI:`PSC_SRC_LO];
    d.inTermOn = {16{inTermEn}} & ~({16{q.pulseOn}} & pulseBits);
    d.eqHigh = eqBits;
    d.outBoostLevel = driveReg[`PSC_BOOST_HI:`PSC_BOOST_LO];
    d.outTermEnable = driveReg[`PSC_BIT_OUT_TERM];
    d.outCurrentHigh = driveReg[`PSC_BIT_OUT_CUR];
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      q <= '0;
      q.strapMode <= 1'b1;
      q.regFile[`PSC_IDX_SIDE] <= `PSC_SIDE_RST;
      q.regFile[`PSC_IDX_INTERM] <= `PSC_INTERM_RST;
      q.auxEnable <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign serRdata = q.rdData;
  assign serRvalid = q.rdValid;
  assign strapMode = q.strapMode;
  assign hsEnable = q.hsEnable;
  assign hsMode = q.hsMode;
  assign hsSource = q.hsSource;
  assign auxEnable = q.auxEnable;
  assign auxMode = q.auxMode;
  assign auxSource = q.auxSource;
  assign inTermOn = q.inTermOn;
  assign eqHigh = q.eqHigh;
  assign outBoostLevel = q.outBoostLevel;
  assign outTermEnable = q.outTermEnable;
  assign outCurrentHigh = q.outCurrentHigh;
endmodule

/* File: rtl/psc_map.svh */
// Register indices, field positions, reset values and timing counts.
// Assumes inclusion by the package and the design modules; the guard stops repeats.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_IDX_W 3
`define PSC_IDX_FAST 3'h0
`define PSC_IDX_SIDE 3'h1
`define PSC_IDX_INTERM 3'h2
`define PSC_IDX_PULSE_AB 3'h3
`define PSC_IDX_PULSE_CD 3'h4
`define PSC_IDX_EQ_AB 3'h5
`define PSC_IDX_EQ_CD 3'h6
`define PSC_IDX_DRIVE 3'h7

`define PSC_BIT_ENABLE 6
`define PSC_MODE_HI 5
`define PSC_MODE_LO 2
`define PSC_SRC_HI 1
`define PSC_SRC_LO 0
`define PSC_BIT_IN_TERM 0
`define PSC_BOOST_HI 3
`define PSC_BOOST_LO 2
`define PSC_BIT_OUT_TERM 1
`define PSC_BIT_OUT_CUR 0

`define PSC_MODE_QUAD 4'h0
`define PSC_FAST_RST 8'h00
`define PSC_SIDE_RST 8'h40
`define PSC_INTERM_RST 8'h01
`define PSC_ZERO_RST 8'h00

`define PSC_STRAP_W 8
`define PSC_CLK_HZ 40000000
`define PSC_PULSE_MS 100
`define PSC_PULSE_CNT_W 22

`endif

/* File: rtl/psc_pkg.sv */
// Types shared by the strap loader and its pin synchroniser.
// Assumes psc_map.svh is on the include path.
`include "psc_map.svh"

package psc_pkg;

  typedef struct packed {
    logic [`PSC_STRAP_W-1:0] stage1;
    logic [`PSC_STRAP_W-1:0] stage2;
  } psc_sync_t;

  typedef struct packed {
    logic [7:0][7:0] regFile;
    logic strapMode;
    logic [7:0] rdData;
    logic rdValid;
    logic [1:0] lastSrc;
    logic pulseOn;
    logic [`PSC_PULSE_CNT_W-1:0] pulseCnt;
    logic hsEnable;
    logic [3:0] hsMode;
    logic [1:0] hsSource;
    logic auxEnable;
    logic [3:0] auxMode;
    logic [1:0] auxSource;
    logic [15:0] inTermOn;
    logic [15:0] eqHigh;
    logic [1:0] outBoostLevel;
    logic outTermEnable;
    logic outCurrentHigh;
  } psc_core_t;

endpackage

/* File: rtl/psc_strap_if.sv */
// Synchronised strap levels passed from the synchroniser to the core.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps

interface psc_strap_if;
  logic strapChannelEnable;
  logic [1:0] strapSourceSelect;
  logic strapEqLevel;
  logic [1:0] strapBoostLevel;
  logic strapOutTerm;
  logic strapOutCurrent;

  modport syncSide (
    output strapChannelEnable,
    output strapSourceSelect,
    output strapEqLevel,
    output strapBoostLevel,
    output strapOutTerm,
    output strapOutCurrent
  );
  modport coreSide (
    input strapChannelEnable,
    input strapSourceSelect,
    input strapEqLevel,
    input strapBoostLevel,
    input strapOutTerm,
    input strapOutCurrent
  );
endinterface

/* File: rtl/psc_strap_sync.sv */
// Two-flop synchroniser for the board strap pins.
// Assumes a reset already released synchronously to clk.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_strap_sync
  import psc_pkg::*;
(
  input wire logic clk,
  input wire logic rstSync_b,
  input wire logic [`PSC_STRAP_W-1:0] strapPins,
  psc_strap_if.syncSide strap
);
  psc_sync_t q;
  psc_sync_t d;

  always_comb begin
    d = q;
    d.stage1 = strapPins;
    // Stage one feeds stage two only
    d.stage2 = q.stage1;
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign strap.strapChannelEnable = q.stage2[0];
  assign strap.strapSourceSelect = q.stage2[2:1];
  assign strap.strapEqLevel = q.stage2[3];
  assign strap.strapBoostLevel = q.stage2[5:4];
  assign strap.strapOutTerm = q.stage2[6];
  assign strap.strapOutCurrent = q.stage2[7];
endmodule

/* File: sim/psc_board_straps.sv */
// Board model: strap pins tied to fixed levels.
// Assumes the bench changes the setting only between tests.
`timescale 1ns/1ps

module psc_board_straps (
  input wire logic [7:0] setting,
  output logic [7:0] strapPins
);
  // Static ties, no timing of their own
  assign strapPins = setting;
endmodule

/* File: sim/psc_strap_loader_props.sv */
// Port checker for the strap loader.
// Assumes binding to psc_strap_loader; rst_b is the raw pin.
`timescale 1ns/1ps

module psc_strap_loader_props
  import psc_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic strapChannelEnable,
  input wire logic [1:0] strapSourceSelect,
  input wire logic strapEqLevel,
  input wire logic [1:0] strapBoostPins,
  input wire logic strapOutTerm,
  input wire logic strapOutCurrent,
  input wire logic serReq,
  input wire logic strapMode,
  input wire logic hsEnable,
  input wire logic [3:0] hsMode,
  input wire logic [1:0] hsSource,
  input wire logic auxEnable,
  input wire logic [3:0] auxMode,
  input wire logic [1:0] auxSource,
  input wire logic [15:0] inTermOn,
  input wire logic [15:0] eqHigh,
  input wire logic [1:0] outBoostLevel,
  input wire logic outTermEnable,
  input wire logic outCurrentHigh
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Eight steady samples cover sync, register and output stages
  sequence s_steady;
    (strapMode && $stable({strapChannelEnable, strapSourceSelect, strapEqLevel,
      strapBoostPins, strapOutTerm, strapOutCurrent}))[*8];
  endsequence
  sequence s_quiet;
    (!strapMode && !serReq)[*3];
  endsequence
  property p_fast;
    s_steady |-> {hsEnable, hsMode, hsSource} == {strapChannelEnable, 4'h0, strapSourceSelect};
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode not from straps");
  property p_aux;
    s_steady |-> {auxEnable, auxMode, auxSource} == {1'b1, 4'h0, strapSourceSelect};
  endproperty
  a_aux: assert property (p_aux) else $error("aux mode not from straps");
  property p_eq;
    s_steady |-> eqHigh == {16{strapEqLevel}};
  endproperty
  a_eq: assert property (p_eq) else $error("eq not copied");
  property p_drive;
    s_steady |-> {outBoostLevel, outTermEnable, outCurrentHigh} ==
      {strapBoostPins, strapOutTerm, strapOutCurrent};
  endproperty
  a_drive: assert property (p_drive) else $error("drive not from straps");
  property p_inTerm;
    s_steady |-> inTermOn == 16'hffff;
  endproperty
  a_inTerm: assert property (p_inTerm) else $error("input term not on");
  property p_accessEnds;
    serReq |=> !strapMode;
  endproperty
  a_accessEnds: assert property (p_accessEnds) else $error("strap mode kept");
  property p_staysOff;
    !strapMode |=> !strapMode;
  endproperty
  a_staysOff: assert property (p_staysOff) else $error("strap mode came back");
  property p_frozen;
    s_quiet |=> $stable({hsEnable, hsMode, hsSource, auxEnable, auxMode, auxSource, eqHigh,
      outBoostLevel, outTermEnable, outCurrentHigh});
  endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved");
endmodule

bind psc_strap_loader psc_strap_loader_props #(.PULSE_CYCLES(PULSE_CYCLES)) props (.*);

/* File: sim/tb_top.sv */
// Self-checking bench for the strap loader.
// Assumes the board model and checker are compiled alongside.
`timescale 1ns/1ps

module tb_top;
  logic clk, rst_b, serReq, serWrite, serRvalid, strapMode, hsEnable, auxEnable;
  logic strapChannelEnable, strapEqLevel, strapOutTerm, strapOutCurrent;
  logic outTermEnable, outCurrentHigh;
  logic [1:0] strapSourceSelect, strapBoostPins, hsSource, auxSource, outBoostLevel;
  logic [2:0] serIdx;
  logic [3:0] hsMode, auxMode;
  logic [7:0] serWdata, serRdata, pins, pinLv, rd;
  logic [7:0] r [8];
  logic [15:0] inTermOn, eqHigh;
  logic [49:0] seen;
  int seed = 26644;
  int bad_count = 0;
  int checks = 0;

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  psc_board_straps board (.setting(pins), .strapPins(pinLv));
  assign {strapOutCurrent, strapOutTerm, strapBoostPins, strapEqLevel, strapSourceSelect,
    strapChannelEnable} = pinLv;
  // Short pulse keeps the run brief
  psc_strap_loader #(.PULSE_CYCLES(20)) dut (.*);
  assign seen = {hsEnable, hsMode, hsSource, auxEnable, auxMode, auxSource, inTermOn,
    eqHigh, outBoostLevel, outTermEnable, outCurrentHigh};

  function automatic logic [7:0] img(logic [7:0] p, int i);
    case (i)
      0: return {1'b0, p[0], 4'h0, p[2:1]};
      1: return {2'b01, 4'h0, p[2:1]};
      2: return 8'h01;
      5, 6: return {8{p[3]}};
      7: return {4'h0, p[5:4], p[6], p[7]};
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [49:0] expOut(logic pulse);
    return {r[0][6:0], r[1][6:0], {16{r[2][0]}} & ~({r[4], r[3]} & {16{pulse}}), r[6], r[5],
      r[7][3:0]};
  endfunction
  task automatic chk(string name, logic [49:0] got, logic [49:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic acc(logic wr, logic [2:0] idx, logic [7:0] wd);
    int n;
    serReq = 1;
    serWrite = wr;
    serIdx = idx;
    serWdata = wd;
    @(negedge clk);
    serReq = 0;
    n = 0;
    while (!wr && serRvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    rd = serRdata;
    if (!wr) chk("read valid", {49'h0, serRvalid}, 50'h1);
    if (wr) r[idx] = wd;
    @(negedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    rst_b = 0;
    serReq = 0;
    serWrite = 0;
    serIdx = 0;
    serWdata = 0;
    pins = 0;
    for (int round = 0; round < 2; round++) begin
      rst_b = 0;
      repeat (20) @(negedge clk);
      rst_b = 1;
      for (int k = 0; k < 10; k++) begin
        // Corners give every source and boost code, then random ties
        pins = (k < 4 && round == 0) ? {4{k[1:0]}} : 8'($random(seed));
        // Long enough for the checker's eight steady samples
        repeat (12) @(negedge clk);
        for (int i = 0; i < 8; i++) r[i] = img(pins, i);
        chk("strap outputs", seen, expOut(0));
        chk("strap mode on", {49'h0, strapMode}, 50'h1);
      end
      for (int i = 0; i < 8; i++) begin
        acc(0, 3'(i), 8'h00);
        chk("strap image", {42'h0, rd}, {42'h0, r[i]});
      end
      pins = ~pins;
      repeat (8) @(negedge clk);
      chk("frozen outputs", seen, expOut(0));
      chk("strap mode", {49'h0, strapMode}, 50'h0);
      $display("strap round done");
    end
    acc(1, 3'h3, 8'hff);
    acc(1, 3'h7, 8'h0e);
    acc(1, 3'h0, {r[0][7:2], ~r[0][1:0]});
    @(negedge clk);
    chk("pulse active", seen, expOut(1));
    repeat (30) @(negedge clk);
    chk("pulse over", seen, expOut(0));
    acc(1, 3'h2, 8'h00);
    acc(1, 3'h5, 8'($random(seed)));
    @(negedge clk);
    chk("serial writes", seen, expOut(0));
    $display("serial test done");
    finish_test;
  end
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    finish_test;
  end
endmodule
